/* hdl/reset_pins.sv */
// reset pin sequencer, bus clock pin control and external interrupt trigger
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "reset_pins_map.svh"

module reset_pins (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire reset_pins_pkg::op_mode_t mode_strap,
  input  wire logic                     stop_mode,
  input  wire logic                     slow_access,
  input  wire logic                     watchdog_timeout,
  input  wire logic                     clock_monitor_fail,
  input  wire logic                     reset_pin_in,
  output wire logic                     reset_pin_out,
  output wire logic                     reset_pin_oe_n,
  input  wire logic                     bus_clock_in,
  output wire logic                     bus_clock_out,
  output wire logic                     bus_clock_oe_n,
  output wire logic                     bus_clk_en,
  input  wire logic                     irq_pin_n,
  output wire logic                     ext_irq_req,
  output wire logic                     core_reset_n,
  output wire reset_pins_pkg::vector_t  reset_vector,
  output wire logic                     int_out,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [3:0]               adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output wire logic [31:0]              dat_o,
  output wire logic                     ack_o
);
  import reset_pins_pkg::*;

  pins_state_t q;
  pins_state_t next_q;

  logic bus_rise;
  logic bus_fall;
  logic req;
  logic wr;
  logic pin_low;
  logic irq_low;
  logic irq_fall;
  logic [3:0] events;
  logic [3:0] w1c;

  // ==========================================================
  // bus clock divider
  // the divider keeps running during a reset sequence so that the counts finish
  // even when stop mode was requested; reset overrides stop
  logic run_div;
  assign run_div  = !stop_mode || (q.seq != SEQ_RUN);
  assign bus_rise = run_div && !q.div;
  assign bus_fall = run_div && q.div && !(slow_access && (q.stretch_cnt != q.stretch_cfg));
  assign bus_clk_en = bus_rise;

  // ==========================================================
  // bus decode
  assign req = cyc_i && stb_i && !q.ack;
  assign wr  = req && we_i && sel_i[0];

  assign pin_low = !q.rst_sync[1];
  assign irq_low = !q.irq_sync[1];
  assign irq_fall = q.irq_prev && irq_low;

  always_comb begin
    next_q = q;
    events = 4'h0;
    w1c    = 4'h0;

    // synchronisers
    next_q.rst_sync    = {q.rst_sync[0], reset_pin_in};
    next_q.irq_sync    = {q.irq_sync[0], irq_pin_n};
    next_q.clk_in_sync = {q.clk_in_sync[0], bus_clock_in};
    next_q.irq_prev    = !irq_low;

    // ========================================================
    // clock divider with stretch
    if (bus_rise) begin
      next_q.div         = 1'b1;
      next_q.stretch_cnt = 2'h0;
    end else if (q.div && run_div) begin
      if (bus_fall) begin
        next_q.div = 1'b0;
      end else begin
        next_q.stretch_cnt = q.stretch_cnt + 2'h1;
      end
    end
    // pin drives only when enabled, not in peripheral mode, not stopped
    next_q.clk_q = next_q.div && q.bus_clk_on && run_div
                   && (q.mode != MODE_SPECIAL_PERIPH);

    // ========================================================
    // reset sequencer
    case (q.seq)
      SEQ_START: begin
        // strap caught on the first edge after release
        next_q.mode       = mode_strap;
        next_q.bus_clk_on = (mode_strap == MODE_SPECIAL_SINGLE);
        next_q.core_rst_n = 1'b1;
        next_q.seq        = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (watchdog_timeout || clock_monitor_fail) begin
          next_q.seq        = SEQ_DRIVE;
          next_q.cnt        = 4'h0;
          next_q.src_clkmon = clock_monitor_fail && !watchdog_timeout;
          next_q.pin_drive  = 1'b1;
          next_q.core_rst_n = 1'b0;
        end else if (pin_low) begin
          next_q.seq        = SEQ_EXTERNAL;
          next_q.core_rst_n = 1'b0;
          next_q.vec        = VEC_RESET;
          events[`ST_EXTERNAL] = 1'b1;
        end
      end
      SEQ_DRIVE: begin
        if (bus_rise) begin
          if (q.cnt == 4'(`DRIVE_CYCLES - 5'd1)) begin
            next_q.pin_drive = 1'b0;
            next_q.cnt       = 4'h0;
            next_q.seq       = SEQ_WAIT;
          end else begin
            next_q.cnt = q.cnt + 4'h1;
          end
        end
      end
      SEQ_WAIT: begin
        if (bus_rise) begin
          if (q.cnt == `SAMPLE_DELAY - 4'd1) begin
            if (pin_low) begin
              // board still holds the pin, so its reset wins
              next_q.vec = VEC_RESET;
              next_q.seq = SEQ_EXTERNAL;
              events[`ST_EXTERNAL] = 1'b1;
            end else begin
              next_q.vec = q.src_clkmon ? VEC_CLKMON : VEC_WATCHDOG;
              events[`ST_WATCHDOG] = !q.src_clkmon;
              events[`ST_CLKMON]   = q.src_clkmon;
              next_q.core_rst_n = 1'b1;
              next_q.seq        = SEQ_RUN;
            end
          end else begin
            next_q.cnt = q.cnt + 4'h1;
          end
        end
      end
      SEQ_EXTERNAL: begin
        if (!pin_low) begin
          next_q.core_rst_n = 1'b1;
          next_q.seq        = SEQ_RUN;
        end
      end
      default: begin
        next_q.seq = SEQ_RUN;
      end
    endcase

    // ========================================================
    // external interrupt trigger
    events[`ST_IRQ_EDGE] = irq_fall;
    if (q.irq_edge && irq_fall && q.irq_en) begin
      events[`ST_IRQ_EDGE] = 1'b1;
    end

    // ========================================================
    // register writes
    next_q.ack = req;
    if (wr) begin
      case (adr_i)
        `OFS_CTRL: begin
          next_q.bus_clk_on  = dat_i[`CTRL_BUS_CLK_ON];
          next_q.irq_edge    = dat_i[`CTRL_IRQ_EDGE];
          next_q.irq_en      = dat_i[`CTRL_IRQ_EN];
          next_q.stretch_cfg = dat_i[`CTRL_STR_HI:`CTRL_STR_LO];
        end
        `OFS_STATUS: begin
          w1c = dat_i[3:0];
        end
        `OFS_MASK: begin
          next_q.mask = dat_i[3:0];
        end
        default: begin
          next_q.mask = q.mask;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_q.status = (q.status & ~w1c) | events;

    // ========================================================
    // read data
    next_q.rdata = 8'h00;
    if (req && !we_i) begin
      case (adr_i)
        `OFS_CTRL: begin
          next_q.rdata[`CTRL_BUS_CLK_ON]         = q.bus_clk_on;
          next_q.rdata[`CTRL_IRQ_EDGE]           = q.irq_edge;
          next_q.rdata[`CTRL_IRQ_EN]             = q.irq_en;
          next_q.rdata[`CTRL_STR_HI:`CTRL_STR_LO] = q.stretch_cfg;
        end
        `OFS_STATUS: begin
          next_q.rdata[3:0] = q.status;
        end
        `OFS_MASK: begin
          next_q.rdata[3:0] = q.mask;
        end
        `OFS_INFO: begin
          next_q.rdata[`INFO_MODE_HI:`INFO_MODE_LO] = q.mode;
          next_q.rdata[`INFO_BUSY]                  = (q.seq != SEQ_RUN);
          next_q.rdata[`INFO_VEC_HI:`INFO_VEC_LO]   = q.vec;
          next_q.rdata[`INFO_CLK_IN]                = q.clk_in_sync[1];
        end
        default: begin
          next_q.rdata = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  // async clear only loads constants; the strap is taken in SEQ_START
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.status      <= `RST_STATUS;
      q.mask        <= `RST_MASK;
      q.stretch_cfg <= `RST_STRETCH;
      q.rst_sync    <= 2'h3;
      q.irq_sync    <= 2'h3;
      q.irq_prev    <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign reset_pin_out  = 1'b0;
  assign reset_pin_oe_n = !q.pin_drive;
  assign bus_clock_out  = q.clk_q;
  assign bus_clock_oe_n = !(q.bus_clk_on && (q.mode != MODE_SPECIAL_PERIPH));
  assign core_reset_n   = q.core_rst_n;
  assign reset_vector   = q.vec;
  // level mode follows the pin; edge mode uses the sticky latch
  assign ext_irq_req    = q.irq_en && (q.irq_edge ? q.status[`ST_IRQ_EDGE] : irq_low);
  assign int_out        = |(q.status & q.mask);
  assign dat_o          = {24'h000000, q.rdata};
  assign ack_o          = q.ack;

endmodule

/* hdl/reset_pins_map.svh */
// offsets, field positions, reset values and counts of the reset and bus clock pin block
// Operation
// - bus clock is half the oscillator rate
// - normal single-chip: bus clock off after reset
// - special single-chip: bus clock on after reset
// - special peripheral: bus clock pin is input
// - stop mode halts every clock output outside a reset sequence
// - bus clock stretched for slow external accesses
// - reset entry asynchronous, exit synchronous
// - internal failure drives open-drain reset low
// - internal source drives pin exactly 16 cycles
// - pin sampled eight cycles after release
// - pin high: watchdog or clock monitor vector
// - pin low: external reset, ordinary vector
// - software picks edge or level interrupt trigger
// - interrupt level-triggered and masked after reset
`ifndef RESET_PINS_MAP_SVH
`define RESET_PINS_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define OFS_CTRL        4'h0
`define OFS_STATUS      4'h4
`define OFS_MASK        4'h8
`define OFS_INFO        4'hC

// ==========================================================
// control register fields
`define CTRL_BUS_CLK_ON 0
`define CTRL_IRQ_EDGE   1
`define CTRL_IRQ_EN     2
`define CTRL_STR_LO     4
`define CTRL_STR_HI     5

// ==========================================================
// status and mask fields
`define ST_WATCHDOG     0
`define ST_CLKMON       1
`define ST_EXTERNAL     2
`define ST_IRQ_EDGE     3

// ==========================================================
// info register fields
`define INFO_MODE_LO    0
`define INFO_MODE_HI    1
`define INFO_BUSY       2
`define INFO_VEC_LO     4
`define INFO_VEC_HI     5
`define INFO_CLK_IN     6

// ==========================================================
// reset values
`define RST_STATUS      4'h0
`define RST_MASK        4'h0
`define RST_STRETCH     2'h0

// ==========================================================
// reset sequence counts in bus clock cycles
`define DRIVE_CYCLES    5'd16
`define SAMPLE_DELAY    4'd8

`endif

/* hdl/reset_pins_pkg.sv */
// types of the reset and bus clock pin block
package reset_pins_pkg;

  // strap-selected operating mode
  typedef enum logic [1:0] {
    MODE_NORMAL_SINGLE,
    MODE_SPECIAL_SINGLE,
    MODE_SPECIAL_PERIPH,
    MODE_EXPANDED
  } op_mode_t;

  typedef enum logic [2:0] {
    SEQ_START,
    SEQ_RUN,
    SEQ_DRIVE,
    SEQ_WAIT,
    SEQ_EXTERNAL
  } seq_state_t;

  typedef enum logic [1:0] {
    VEC_RESET,
    VEC_WATCHDOG,
    VEC_CLKMON
  } vector_t;

  typedef struct packed {
    op_mode_t   mode;
    logic [1:0] rst_sync;
    logic [1:0] irq_sync;
    logic [1:0] clk_in_sync;
    logic       irq_prev;
    logic       div;
    logic [1:0] stretch_cnt;
    logic       clk_q;
    seq_state_t seq;
    logic [3:0] cnt;
    logic       src_clkmon;
    logic       pin_drive;
    logic       core_rst_n;
    vector_t    vec;
    logic       bus_clk_on;
    logic       irq_edge;
    logic       irq_en;
    logic [1:0] stretch_cfg;
    logic [3:0] status;
    logic [3:0] mask;
    logic       ack;
    logic [7:0] rdata;
  } pins_state_t;

endpackage

/* testbench/reset_pins_chk.sv */
// port assertions of the reset and bus clock pin block
`timescale 1ns/1ps
module reset_pins_chk (
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire reset_pins_pkg::op_mode_t mode_strap,
  input wire logic                     stop_mode,
  input wire logic                     slow_access,
  input wire logic                     watchdog_timeout,
  input wire logic                     clock_monitor_fail,
  input wire logic                     reset_pin_out,
  input wire logic                     reset_pin_oe_n,
  input wire logic                     bus_clock_out,
  input wire logic                     bus_clock_oe_n,
  input wire logic                     bus_clk_en,
  input wire logic                     core_reset_n,
  input wire logic                     cyc_i,
  input wire logic                     stb_i,
  input wire logic                     ack_o
);
  import reset_pins_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // bus cycles seen while the pin is pulled
  logic [5:0] pulses;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) pulses <= 6'h00;
    else if (reset_pin_oe_n) pulses <= 6'h00;
    else if (bus_clk_en) pulses <= pulses + 6'h01;
  end
  // ==========================================================
  // properties
  property p_open_drain; reset_pin_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin data not low");
  property p_enter;
    core_reset_n && reset_pin_oe_n && (watchdog_timeout || clock_monitor_fail)
      |=> !reset_pin_oe_n && !core_reset_n;
  endproperty
  a_enter: assert property (p_enter) else $error("internal source not driven");
  property p_len; $rose(reset_pin_oe_n) |-> pulses == 6'd16; endproperty
  a_len: assert property (p_len) else $error("pin drive length wrong");
  property p_hold; $rose(reset_pin_oe_n) |-> !core_reset_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("left reset before sample");
  property p_half; bus_clk_en |=> !bus_clk_en; endproperty
  a_half: assert property (p_half) else $error("bus clock above half rate");
  property p_rate;
    bus_clk_en && !slow_access && !stop_mode ##1 !slow_access && !stop_mode |=> bus_clk_en;
  endproperty
  a_rate: assert property (p_rate) else $error("bus clock below half rate");
  property p_periph;
    core_reset_n && mode_strap == MODE_SPECIAL_PERIPH |-> bus_clock_oe_n && !bus_clock_out;
  endproperty
  a_periph: assert property (p_periph) else $error("clock pin driven as input");
  property p_stop; (core_reset_n && stop_mode) [*3] |-> !bus_clock_out; endproperty
  a_stop: assert property (p_stop) else $error("bus clock runs in stop");
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer malformed");
  c_release: cover property ($rose(reset_pin_oe_n));
  c_stretch: cover property (bus_clk_en && slow_access);
  c_stop: cover property (stop_mode && core_reset_n);
endmodule

/* testbench/reset_board.sv */
// board side: pulled-up reset pin, reset switch and external bus clock
`timescale 1ns/1ps
module reset_board (
  input  wire logic clk,
  input  wire logic press,
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe_n,
  output logic      reset_pin_in,
  output logic      bus_clock_in
);
  int hold = 0;
  // 70 clocks covers 32 bus cycles with margin
  always @(posedge clk) if (press) hold <= 70; else if (hold > 0) hold <= hold - 1;
  // the info register samples this clock in every mode
  always @(posedge clk) bus_clock_in <= (bus_clock_in === 1'b0);
  assign reset_pin_in = !(hold > 0 || (!reset_pin_oe_n && !reset_pin_out));
endmodule

/* testbench/test_reset_pins.sv */
// self-checking bench of the reset and bus clock pin block
`timescale 1ns/1ps
`include "reset_pins_map.svh"
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin \
  n_errors++; $display("mismatch %0t %s", $time, m); end end
module test_reset_pins;
  import reset_pins_pkg::*;
  logic        clk = 0, resetn = 1, stop_mode = 0, slow_access = 0, press = 0;
  logic        watchdog_timeout = 0, clock_monitor_fail = 0, irq_pin_n = 1;
  logic        cyc_i = 0, stb_i = 0, we_i = 0, bus_clock_in, reset_pin_in, reset_pin_out;
  logic        reset_pin_oe_n, bus_clock_out, bus_clock_oe_n, bus_clk_en, ext_irq_req;
  logic        core_reset_n, int_out, ack_o;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  op_mode_t    mode_strap = MODE_NORMAL_SINGLE;
  vector_t     reset_vector;
  vector_t     exp_q[$];
  int          n_errors = 0, checks = 0, seed = 32'h2c2f, ticks = 0, st = 0, r, t;
  reset_pins  DUT (.*);
  reset_board board (.*);
  initial forever #50 clk = ~clk;
  // ==========================================================
  // tasks
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do @(posedge clk); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e, "register read")
  endtask
  task automatic do_reset(input op_mode_t m);
    resetn     <= 1'b0;
    mode_strap <= m;
    #1;
    `CHK(core_reset_n, 1'b0, "reset entry")
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // a hang counts as a failure
  always @(posedge clk) if (++ticks > 5000) begin
    n_errors++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    for (int m = 0; m < 4; m++) begin
      do_reset(op_mode_t'(m));
      `CHK(bus_clock_oe_n, m != 1, "clock pin drive")
      rdchk(`OFS_CTRL, {31'h0, m == 1});
      rdchk(`OFS_STATUS, 32'h0);
      rdchk(`OFS_MASK, 32'h0);
      bus(1'b0, `OFS_INFO, 32'h0);
      `CHK(rd[5:0], {4'h0, 2'(m)}, "mode info")
      // reads are three edges apart and the board toggles every edge
      t = rd[6];
      bus(1'b0, `OFS_INFO, 32'h0);
      `CHK(rd[6], (t == 0), "clock pin input seen")
      bus(1'b1, `OFS_CTRL, {31'h0, m != 1});
      repeat (3) @(posedge clk);
      `CHK(bus_clock_oe_n, m == 1 || m == 2, "clock pin by software")
    end
    rdchk(4'h2, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h5);
    irq_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(ext_irq_req, 1'b1, "level request")
    irq_pin_n <= 1'b1;
    st = 8;
    repeat (4) @(posedge clk);
    `CHK(ext_irq_req, 1'b0, "level request gone")
    bus(1'b1, `OFS_CTRL, 32'h7);
    `CHK(ext_irq_req, 1'b1, "edge request held")
    r = $random(seed);
    bus(1'b1, `OFS_MASK, r);
    rdchk(`OFS_MASK, r & 32'hF);
    `CHK(int_out, (r & st) != 0, "masked interrupt")
    bus(1'b1, `OFS_STATUS, 32'h8);
    st = 0;
    `CHK(ext_irq_req, 1'b0, "edge request cleared")
    `CHK(int_out, 1'b0, "interrupt cleared")
    bus(1'b1, `OFS_CTRL, 32'h1);
    for (int s = 0; s < 3; s++) begin
      exp_q.push_back(s == 0 ? VEC_WATCHDOG : s == 1 ? VEC_CLKMON : VEC_RESET);
      watchdog_timeout   <= (s != 1);
      clock_monitor_fail <= (s == 1);
      press              <= (s == 2);
      @(posedge clk);
      watchdog_timeout   <= 1'b0;
      clock_monitor_fail <= 1'b0;
      press              <= 1'b0;
      @(posedge clk);
      `CHK(reset_pin_oe_n, 1'b0, "pin pulled")
      while (core_reset_n !== 1'b1) @(posedge clk);
      `CHK(reset_vector, exp_q.pop_front(), "reset vector")
      st = 1 << s;
      rdchk(`OFS_STATUS, st);
      bus(1'b1, `OFS_MASK, st);
      `CHK(int_out, 1'b1, "source interrupt")
      bus(1'b1, `OFS_STATUS, st);
      `CHK(int_out, 1'b0, "source interrupt cleared")
    end
    stop_mode <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(bus_clock_out, 1'b0, "stopped bus clock")
    stop_mode <= 1'b0;
    r = $random(seed) & 3;
    bus(1'b1, `OFS_CTRL, 32'h1 | (r << 4));
    slow_access <= 1'b1;
    repeat (2) begin
      do @(posedge clk); while (bus_clk_en !== 1'b1);
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (bus_clk_en !== 1'b1);
    end
    `CHK(t, r + 2, "stretched period")
    @(posedge clk);
    `CHK(bus_clock_out, 1'b1, "bus clock high phase")
    slow_access <= 1'b0;
    print_verdict();
  end
endmodule
bind reset_pins reset_pins_chk chk (.*);
